// ### core/power_on_strap_config.sv
// power-on strap capture, clock-stop state and config register
module power_on_strap_config
  import strap_cfg_pkg::*;
#(
  parameter logic [63:0] RATIO_TABLE = 64'hfedc_ba98_7654_3210
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        address_bit15_strap_n,
  input  wire logic        bus_speed_sel,
  input  wire logic        intc_data0_strap,
  input  wire logic        bus_request0_n,
  input  wire logic        addr20_mask_n,
  input  wire logic        ignore_numeric_error_n,
  input  wire logic        maskable_interrupt_in,
  input  wire logic        nonmaskable_interrupt_in,
  input  wire logic        clock_stop_request_n,
  input  wire logic        priority_snoop_req,
  input  wire logic        symmetric_snoop_req,
  output logic             snoop_ack,
  output logic             interrupt_latch_en,
  output logic             intc_global_enable,
  output logic [3:0]       core_multiplier,
  output logic [2:0]       power_state
);
`include "strap_cfg_params.svh"

  // ============================================================
  // pin synchronisers
  strap_pins_t pins_raw;
  strap_pins_t pins;
  logic        stop_req_n_sync;

  assign pins_raw = '{address_bit15_strap_n, bus_speed_sel, intc_data0_strap, bus_request0_n,
                      addr20_mask_n, ignore_numeric_error_n, maskable_interrupt_in,
                      nonmaskable_interrupt_in};

  pin_sync3 #(.WIDTH(9)) u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .pin_in  ({pins_raw, clock_stop_request_n}),
    .pin_out ({pins, stop_req_n_sync})
  );

  // ============================================================
  // strap capture on reset release
  logic       in_reset_d;
  logic       next_in_reset_d;
  strap_cap_t cap;
  strap_cap_t next_cap;
  logic       capture_now;
  // multiplier is registered so the data output comes from a flop
  logic [3:0] mult;
  logic [3:0] next_mult;

  // release is the first clock after srst falls
  assign capture_now = in_reset_d & ~srst;

  always_comb begin
    next_in_reset_d = srst;
    next_cap        = cap;
    next_mult       = RATIO_TABLE[cap.ratio_code*4 +: 4];
    if (capture_now) begin
      next_cap.fast_wake_en = ~pins.address_bit15_strap_n;
      next_cap.bus_100mhz   = pins.bus_speed_sel;
      next_cap.intc_enable  = pins.intc_data0_strap;
      next_cap.bus_req_seen = ~pins.bus_request0_n;
      next_cap.ratio_code   = {~pins.nonmaskable_interrupt_in, ~pins.maskable_interrupt_in,
                               pins.ignore_numeric_error_n, pins.addr20_mask_n};
    end
  end

  // hold straps until the next reset; reset itself clears to defaults
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      in_reset_d <= 1'b1;
      cap        <= '{1'b0, 1'b0, 1'b1, 1'b0, `RATIO_RESET};
      mult       <= RATIO_TABLE[`RATIO_RESET*4 +: 4];
    end else begin
      in_reset_d <= next_in_reset_d;
      cap        <= next_cap;
      mult       <= next_mult;
    end
  end

  // ============================================================
  // clock-stop state machine
  pwr_state_t state;
  pwr_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (!stop_req_n_sync && !in_reset_d) begin
          next_state = cap.fast_wake_en ? ST_FASTWAKE : ST_GRANT;
        end
      end
      ST_GRANT, ST_FASTWAKE: begin
        if (stop_req_n_sync) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // snoop service and interrupt latching per state
  always_comb begin
    case (state)
      ST_FASTWAKE: begin
        snoop_ack          = priority_snoop_req;
        interrupt_latch_en = 1'b0;
      end
      default: begin
        snoop_ack          = priority_snoop_req | symmetric_snoop_req;
        interrupt_latch_en = 1'b1;
      end
    endcase
  end

  assign power_state        = state;
  assign intc_global_enable = cap.intc_enable;
  assign core_multiplier    = mult;

  // ============================================================
  // power-on configuration word
  logic [31:0] poc_word;
  always_comb begin
    poc_word                                        = 32'h0000_0000;
    poc_word[`POC_FASTWAKE_BIT]                     = cap.fast_wake_en;
    poc_word[`POC_BUSSPEED_BIT]                     = cap.bus_100mhz;
    poc_word[`POC_RATIO_MSB:`POC_RATIO_LSB]         = cap.ratio_code;
  end

  // ============================================================
  // avalon slave: writes complete at once, reads wait one cycle
  logic        rd_pending;
  logic        next_rd_pending;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [31:0] scratch;
  logic [31:0] next_scratch;

  always_comb begin
    next_rd_pending = avs_read & ~rd_pending;
    next_rdata      = rdata;
    next_scratch    = scratch;
    if (avs_read && !rd_pending) begin
      case (avs_address)
        `POC_OFFSET:   next_rdata = poc_word;
        `CTRL_OFFSET:  next_rdata = scratch;
        `STATE_OFFSET: next_rdata = {28'h0000000, cap.bus_req_seen, state};
        default:       next_rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && avs_address == `CTRL_OFFSET) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          next_scratch[b*8 +: 8] = avs_writedata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_pending <= 1'b0;
      rdata      <= 32'h0000_0000;
      scratch    <= `CTRL_RESET;
    end else begin
      rd_pending <= next_rd_pending;
      rdata      <= next_rdata;
      scratch    <= next_scratch;
    end
  end

  assign avs_waitrequest = avs_read & ~rd_pending;
  assign avs_readdata    = rdata;

  // ============================================================
  // assertions
  property p_hold_straps;
    @(posedge sys_clk) disable iff (srst)
      !capture_now |=> $stable(cap);
  endproperty
  a_hold_straps: assert property (p_hold_straps) else $error("straps changed outside release");

  property p_stop_entry;
    @(posedge sys_clk) disable iff (srst)
      (state == ST_RUN && !stop_req_n_sync && !in_reset_d) |=>
        (state == (cap.fast_wake_en ? ST_FASTWAKE : ST_GRANT));
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("wrong clock-stop state entered");

  property p_fastwake_snoop;
    @(posedge sys_clk) disable iff (srst)
      (state == ST_FASTWAKE) |-> (!interrupt_latch_en && snoop_ack == priority_snoop_req);
  endproperty
  a_fastwake_snoop: assert property (p_fastwake_snoop) else $error("fast-wake snoop or interrupt wrong");

  property p_bit5;
    @(posedge sys_clk) disable iff (srst)
      capture_now |=> (poc_word[5] == $past(~pins.address_bit15_strap_n));
  endproperty
  a_bit5: assert property (p_bit5) else $error("fast-wake bit not reported");

  property p_bit19;
    @(posedge sys_clk) disable iff (srst)
      capture_now |=> (poc_word[19] == $past(pins.bus_speed_sel));
  endproperty
  a_bit19: assert property (p_bit19) else $error("bus speed bit not reported");

  property p_intc;
    @(posedge sys_clk) disable iff (srst)
      capture_now |=> (intc_global_enable == $past(pins.intc_data0_strap));
  endproperty
  a_intc: assert property (p_intc) else $error("controller enable not strapped");

  property p_ratio;
    @(posedge sys_clk) disable iff (srst)
      (avs_read && !rd_pending && avs_address == `POC_OFFSET) |=>
        (avs_readdata[`POC_RATIO_MSB:`POC_RATIO_LSB] == cap.ratio_code);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio field mismatch");

  property p_ratio_cap;
    @(posedge sys_clk) disable iff (srst)
      capture_now |=> (cap.ratio_code[0] == $past(pins.addr20_mask_n)) ##3 $stable(cap.ratio_code);
  endproperty
  a_ratio_cap: assert property (p_ratio_cap) else $error("ratio not latched at release");

  property p_read_answer;
    @(posedge sys_clk) disable iff (srst)
      (avs_read && !rd_pending) |=> !avs_waitrequest;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  property p_reset_defaults;
    @(posedge sys_clk)
      srst |=> (intc_global_enable && state == ST_RUN && cap.ratio_code == `RATIO_RESET);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

  property p_grant_service;
    @(posedge sys_clk) disable iff (srst)
      (state == ST_GRANT) |->
        (interrupt_latch_en && snoop_ack == (priority_snoop_req || symmetric_snoop_req));
  endproperty
  a_grant_service: assert property (p_grant_service) else $error("grant state snoop or interrupt wrong");

  property p_stop_exit;
    @(posedge sys_clk) disable iff (srst)
      (state != ST_RUN && stop_req_n_sync) |=> (state == ST_RUN);
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("clock-stop state not left");

  // ============================================================
  // register bus behaviour
  property p_write_nowait;
    @(posedge sys_clk) disable iff (srst)
      (avs_write && !avs_read) |-> !avs_waitrequest;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write made to wait");

  property p_scratch_write;
    @(posedge sys_clk) disable iff (srst)
      (avs_write && avs_address == `CTRL_OFFSET && avs_byteenable == 4'hf) |=>
        (scratch == $past(avs_writedata));
  endproperty
  a_scratch_write: assert property (p_scratch_write) else $error("scratch write lost");

  property p_unmapped_zero;
    @(posedge sys_clk) disable iff (srst)
      (avs_read && !rd_pending && avs_address != `POC_OFFSET && avs_address != `CTRL_OFFSET &&
       avs_address != `STATE_OFFSET) |=> (avs_readdata == 32'h0000_0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_state_word;
    @(posedge sys_clk) disable iff (srst)
      (avs_read && !rd_pending && avs_address == `STATE_OFFSET) |=>
        (avs_readdata[3] == cap.bus_req_seen);
  endproperty
  a_state_word: assert property (p_state_word) else $error("state word request bit wrong");
endmodule : power_on_strap_config

// ### core/strap_cfg_params.svh
// constants for the power-on strap configuration block
`ifndef STRAP_CFG_PARAMS_SVH
`define STRAP_CFG_PARAMS_SVH
// ============================================================
// register map (avalon word byte addresses)
`define POC_OFFSET        4'h0
`define CTRL_OFFSET       4'h4
`define STATE_OFFSET      4'h8
// ============================================================
// power-on configuration field positions
`define POC_FASTWAKE_BIT  5
`define POC_BUSSPEED_BIT  19
`define POC_RATIO_LSB     22
`define POC_RATIO_MSB     25
// ============================================================
// reset values
`define CTRL_RESET        32'h0000_0000
`define RATIO_RESET       4'h0
// ============================================================
// timing: one read-data wait cycle
`define BUS_WAIT_CYCLES   1
`endif

// ### core/strap_cfg_pkg.sv
// types for the power-on strap configuration block
package strap_cfg_pkg;
  // ============================================================
  // power state of the clock-stop logic
  typedef enum logic [2:0] {
    ST_RUN      = 3'b001,
    ST_GRANT    = 3'b010,
    ST_FASTWAKE = 3'b100
  } pwr_state_t;

  // straps captured at reset release
  typedef struct packed {
    logic       fast_wake_en;
    logic       bus_100mhz;
    logic       intc_enable;
    logic       bus_req_seen;
    logic [3:0] ratio_code;
  } strap_cap_t;

  // raw strap pins, synchronised
  typedef struct packed {
    logic address_bit15_strap_n;
    logic bus_speed_sel;
    logic intc_data0_strap;
    logic bus_request0_n;
    logic addr20_mask_n;
    logic ignore_numeric_error_n;
    logic maskable_interrupt_in;
    logic nonmaskable_interrupt_in;
  } strap_pins_t;
endpackage : strap_cfg_pkg

// ### core/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  // ============================================================
  // sync chain per bit
  logic [WIDTH-1:0] s1, s2, s3, held;
  logic [WIDTH-1:0] next_s1, next_s2, next_s3, next_held;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // take a change only when stages two and three agree; in reset follow stage three
      always_comb begin
        next_s1[i]   = pin_in[i];
        next_s2[i]   = s1[i];
        next_s3[i]   = s2[i];
        next_held[i] = (srst || (s2[i] == s3[i])) ? s3[i] : held[i];
      end
    end
  endgenerate

  // chain keeps running through reset so strap levels are settled at release
  always_ff @(posedge sys_clk) begin
    s1   <= next_s1;
    s2   <= next_s2;
    s3   <= next_s3;
    held <= next_held;
  end

  assign pin_out = held;
endmodule : pin_sync3

// ### verification/strap_source.sv
// system-side model driving the reset-time strap pins
module strap_source
  import strap_cfg_pkg::*;
(
  input  wire logic        hold,
  input  wire strap_pins_t cfg,
  output strap_pins_t      pins
);
  // ============================================================
  // straps during configuration, normal traffic afterwards
  always_comb begin
    pins = cfg;
    pins.bus_request0_n = ~hold;
    if (!hold) begin
      pins.address_bit15_strap_n = ~cfg.address_bit15_strap_n;
      pins.addr20_mask_n = ~cfg.addr20_mask_n;
      pins.ignore_numeric_error_n = ~cfg.ignore_numeric_error_n;
      pins.maskable_interrupt_in = ~cfg.maskable_interrupt_in;
      pins.nonmaskable_interrupt_in = ~cfg.nonmaskable_interrupt_in;
      pins.bus_speed_sel = 1'b0;
      pins.intc_data0_strap = 1'b0;
    end
  end
endmodule : strap_source

// ### verification/tb_top.sv
// self-checking bench for the power-on strap configuration block
`include "strap_cfg_params.svh"
module tb_top
  import strap_cfg_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] TABLE = 64'h0123_4567_89ab_cdef;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        hold = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  strap_pins_t cfg = 8'h00;
  strap_pins_t pins;
  logic        clock_stop_request_n = 1'b1;
  logic        priority_snoop_req = 1'b0;
  logic        symmetric_snoop_req = 1'b0;
  logic        snoop_ack;
  logic        interrupt_latch_en;
  logic        intc_global_enable;
  logic [3:0]  core_multiplier;
  logic [2:0]  power_state;
  logic [31:0] rd;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  // ============================================================
  // clock, partner and design
  always #2 sys_clk = ~sys_clk;
  strap_source far (.hold(hold), .cfg(cfg), .pins(pins));
  power_on_strap_config #(.RATIO_TABLE(TABLE)) dut (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .address_bit15_strap_n(pins.address_bit15_strap_n),
    .bus_speed_sel(pins.bus_speed_sel), .intc_data0_strap(pins.intc_data0_strap),
    .bus_request0_n(pins.bus_request0_n), .addr20_mask_n(pins.addr20_mask_n),
    .ignore_numeric_error_n(pins.ignore_numeric_error_n),
    .maskable_interrupt_in(pins.maskable_interrupt_in),
    .nonmaskable_interrupt_in(pins.nonmaskable_interrupt_in),
    .clock_stop_request_n(clock_stop_request_n),
    .priority_snoop_req(priority_snoop_req),
    .symmetric_snoop_req(symmetric_snoop_req), .snoop_ack(snoop_ack),
    .interrupt_latch_en(interrupt_latch_en),
    .intc_global_enable(intc_global_enable),
    .core_multiplier(core_multiplier), .power_state(power_state));

  // ============================================================
  // reporting and shared helpers
  task automatic conclude;
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // avalon read: hold until waitrequest is sampled low
  task automatic bus_read(input logic [3:0] addr);
    @(posedge sys_clk);
    avs_address <= addr;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_read

  // avalon write: hold until waitrequest is sampled low
  task automatic bus_write(input logic [3:0] addr, input logic [31:0] data, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= addr;
    avs_writedata <= data;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_write

  // reset with straps applied, straps released at reset release
  task automatic do_reset(input strap_pins_t c);
    @(posedge sys_clk);
    cfg <= c;
    hold <= 1'b1;
    srst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    hold <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : do_reset

  // config word, enable, multiplier and state word after reset
  task automatic chk_cfg(input logic [3:0] code, input logic [3:0] mult, input logic fw, input logic bs,
                         input logic en);
    bus_read(`POC_OFFSET);
    chk(rd[`POC_RATIO_MSB:`POC_RATIO_LSB], code);
    chk(rd[`POC_FASTWAKE_BIT], fw);
    chk(rd[`POC_BUSSPEED_BIT], bs);
    chk(core_multiplier, mult);
    chk(intc_global_enable, en);
    bus_read(`STATE_OFFSET);
    chk(rd[3:0], 4'h9);
  endtask : chk_cfg

  task automatic wait_state(input logic [2:0] exp);
    for (int i = 0; i < 20 && power_state !== exp; i++) @(posedge sys_clk);
    chk(power_state, exp);
  endtask : wait_state

  // ============================================================
  // scenarios
  task automatic scen_fast;
    do_reset(8'h09);
    chk_cfg(4'h5, 4'ha, 1'b1, 1'b0, 1'b0);
    clock_stop_request_n <= 1'b0;
    priority_snoop_req <= 1'b1;
    wait_state(ST_FASTWAKE);
    chk(snoop_ack, 1'b1);
    chk(interrupt_latch_en, 1'b0);
    priority_snoop_req <= 1'b0;
    symmetric_snoop_req <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk(snoop_ack, 1'b0);
    symmetric_snoop_req <= 1'b0;
    clock_stop_request_n <= 1'b1;
    wait_state(ST_RUN);
  endtask : scen_fast

  task automatic scen_grant;
    do_reset(8'he6);
    chk_cfg(4'ha, 4'h5, 1'b0, 1'b1, 1'b1);
    clock_stop_request_n <= 1'b0;
    wait_state(ST_GRANT);
    symmetric_snoop_req <= 1'b1;
    @(posedge sys_clk);
    chk(snoop_ack, 1'b1);
    chk(interrupt_latch_en, 1'b1);
    symmetric_snoop_req <= 1'b0;
    clock_stop_request_n <= 1'b1;
    wait_state(ST_RUN);
  endtask : scen_grant

  // scratch register lanes, and a refused write to the config word
  task automatic scen_scratch;
    bus_read(`CTRL_OFFSET);
    chk(rd, `CTRL_RESET);
    bus_write(`CTRL_OFFSET, 32'ha5c3_5a3c, 4'hf);
    bus_read(`CTRL_OFFSET);
    chk(rd, 32'ha5c3_5a3c);
    bus_write(`CTRL_OFFSET, 32'h1111_1111, 4'h2);
    bus_read(`CTRL_OFFSET);
    chk(rd, 32'ha5c3_113c);
    bus_write(`POC_OFFSET, 32'hffff_ffff, 4'hf);
    bus_read(`POC_OFFSET);
    chk(rd, (32'h0000_000a << `POC_RATIO_LSB) | (32'h0000_0001 << `POC_BUSSPEED_BIT));
  endtask : scen_scratch

  task automatic scen_unmapped;
    bus_read(4'hc);
    chk(rd, 32'h0000_0000);
  endtask : scen_unmapped

  // ============================================================
  // timeout guard and main sequence
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    scen_fast();
    scen_grant();
    scen_scratch();
    scen_unmapped();
    conclude();
  end
endmodule : tb_top
